/* src/cpu_copro_reset_generator.sv */
/*
  reset generator: turns board, keyboard, port and shutdown triggers into timed resets.
  assumes io triggers and special-cycle strobes come from logic on core_clk; pins are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_copro_reset_generator
  import reset_gen_pkg::*;
#(
  parameter int PRE_DELAY = PRE_DELAY_CYCLES
)(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              boardResetIn,
  input  wire logic              kbdCpuResetReqN,
  input  wire logic              compatFeatureEnable,
  input  wire io_trigger_type    ioTrig,
  input  wire special_cycle_type specialCycle,
  output logic                   cpuResetOut,
  output logic                   coproResetOut,
  output logic                   cpuBusyOutN,
  output logic                   readyOutN,
  output logic                   configDefaultsLoad
);
  // counters share one width; a count that does not fit would be cut to that width and end early
  if (PRE_DELAY < 1 || PRE_DELAY >= 2**CNT_W) begin : g_bad_pre_delay
    $error("PRE_DELAY out of range");
  end
  if (COPRO_PULSE_CYCLES >= 2**CNT_W || READY_HOLD_CYCLES >= 2**CNT_W) begin : g_bad_counts
    $error("pulse counts exceed counter width");
  end
  if (CPU_PULSE_CYCLES < 1 || WAIT_STATES > 3) begin : g_bad_timing
    $error("pulse or wait-state count unusable");
  end

  // one counter width serves every timer but the two-bit halt wait; the longest count sets it
  logic          brdMeta, brdSync, kbdMeta, kbdSync, kbdPrev;
  cpu_state_type cpuState_reg;
  logic [CNT_W-1:0] cpuCnt_reg, coproCnt_reg, readyHold_reg, busyCnt_reg;
  logic          coproPulse_reg, haltAck_reg;
  logic [1:0]    haltWait_reg;
  logic          shutdownHit, haltHit, kbdEvent, delayedReq;

  // pins pass two flops before use
  // keyboard request is edge-taken so a held-low pin gives one pulse only
  always_ff @(posedge core_clk) begin
    brdMeta <= boardResetIn;
    brdSync <= brdMeta;
    kbdMeta <= kbdCpuResetReqN;
    kbdSync <= kbdMeta;
    kbdPrev <= kbdSync;
  end

  // special-cycle decode; other cycle codes are not this block's concern
  assign shutdownHit = specialCycle.valid && !specialCycle.dataCtrl && specialCycle.writeRead
                       && !specialCycle.byteLane0EnableN;
  assign haltHit     = specialCycle.valid && !specialCycle.dataCtrl && specialCycle.writeRead
                       && specialCycle.byteLane0EnableN;
  // falling edge of the synced request; the pin idles high so reset leaves no false edge
  assign kbdEvent    = !kbdSync && kbdPrev;
  assign delayedReq  = ioTrig.port92Bit0Set || (ioTrig.portEfRead && compatFeatureEnable);

  // processor reset sequencer; board reset outranks all else
  always_ff @(posedge core_clk) begin
    if (reset || brdSync) begin
      cpuState_reg <= CPU_BOARD;
      cpuCnt_reg   <= '0;
    end else begin
      unique case (cpuState_reg)
        CPU_BOARD: begin
          // reset holds past the busy lead-in, then falls
          if (cpuCnt_reg == CNT_W'(BUSY_MARGIN_CYCLES)) begin
            cpuState_reg <= CPU_IDLE;
            cpuCnt_reg   <= '0;
          end else begin
            cpuCnt_reg <= cpuCnt_reg + 1'b1;
          end
        end
        CPU_IDLE: begin
          // priority: keyboard, then shutdown, then the delayed port request; the rest is dropped
          if (kbdEvent) begin
            cpuState_reg <= CPU_PULSE;
            cpuCnt_reg   <= '0;
          end else if (shutdownHit) begin
            cpuState_reg <= CPU_ACK;
            cpuCnt_reg   <= '0;
          end else if (delayedReq) begin
            cpuState_reg <= CPU_DELAY;
            cpuCnt_reg   <= '0;
          end
        end
        CPU_DELAY: begin
          // further port requests during the wait are ignored
          if (cpuCnt_reg == CNT_W'(PRE_DELAY - 1)) begin
            cpuState_reg <= CPU_PULSE;
            cpuCnt_reg   <= '0;
          end else begin
            cpuCnt_reg <= cpuCnt_reg + 1'b1;
          end
        end
        CPU_ACK: begin
          // ready goes out after two wait states, pulse starts on the same edge
          if (cpuCnt_reg == CNT_W'(WAIT_STATES)) begin
            cpuState_reg <= CPU_PULSE;
            cpuCnt_reg   <= '0;
          end else begin
            cpuCnt_reg <= cpuCnt_reg + 1'b1;
          end
        end
        CPU_PULSE: begin
          // last count drops the pin and returns to idle on the same edge
          if (cpuCnt_reg == CNT_W'(CPU_PULSE_CYCLES - 1)) begin
            cpuState_reg <= CPU_IDLE;
            cpuCnt_reg   <= '0;
          end else begin
            cpuCnt_reg <= cpuCnt_reg + 1'b1;
          end
        end
        default: begin
          cpuState_reg <= CPU_IDLE;
          cpuCnt_reg   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || brdSync) begin
      // pin copy looks one state ahead so the pulse leaves a flop with the exact width
      cpuResetOut <= 1'b1;
    end else begin
      cpuResetOut <= (cpuState_reg == CPU_BOARD && cpuCnt_reg != CNT_W'(BUSY_MARGIN_CYCLES))
                     || (cpuState_reg == CPU_IDLE && kbdEvent)
                     || (cpuState_reg == CPU_DELAY && cpuCnt_reg == CNT_W'(PRE_DELAY - 1))
                     || (cpuState_reg == CPU_ACK && cpuCnt_reg == CNT_W'(WAIT_STATES))
                     || (cpuState_reg == CPU_PULSE && cpuCnt_reg != CNT_W'(CPU_PULSE_CYCLES - 1));
    end
  end

  // busy asserted through board reset and nine clocks beyond the reset's fall
  always_ff @(posedge core_clk) begin
    if (reset || brdSync) begin
      busyCnt_reg <= '0;
      cpuBusyOutN <= 1'b0;
    end else if (cpuState_reg == CPU_BOARD) begin
      busyCnt_reg <= '0;
      cpuBusyOutN <= 1'b0;
    end else if (busyCnt_reg != CNT_W'(BUSY_MARGIN_CYCLES)) begin
      busyCnt_reg <= busyCnt_reg + 1'b1;
      cpuBusyOutN <= 1'b0;
    end else begin
      cpuBusyOutN <= 1'b1;
    end
  end

  // coprocessor reset pulse then ready hold-off
  always_ff @(posedge core_clk) begin
    if (reset || brdSync) begin
      coproPulse_reg <= 1'b1;
      coproCnt_reg   <= '0;
      readyHold_reg  <= '0;
    end else if (ioTrig.coproResetPortWrite) begin
      coproPulse_reg <= 1'b1;
      coproCnt_reg   <= '0;
      readyHold_reg  <= '0;
    end else if (coproPulse_reg) begin
      // the hold-off count loads as the pulse ends
      if (coproCnt_reg == CNT_W'(COPRO_PULSE_CYCLES - 1)) begin
        coproPulse_reg <= 1'b0;
        readyHold_reg  <= CNT_W'(READY_HOLD_CYCLES);
      end
      coproCnt_reg <= coproCnt_reg + 1'b1;
    end else if (readyHold_reg != '0) begin
      readyHold_reg <= readyHold_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || brdSync) begin
      // a repeated port write restarts the pulse, so back-to-back writes lengthen it
      coproResetOut <= 1'b1;
    end else begin
      coproResetOut <= ioTrig.coproResetPortWrite
                       || (coproPulse_reg && coproCnt_reg != CNT_W'(COPRO_PULSE_CYCLES - 1));
    end
  end

  // halt: ready after two wait states only
  always_ff @(posedge core_clk) begin
    if (reset || brdSync) begin
      haltAck_reg  <= 1'b0;
      haltWait_reg <= '0;
    end else if (haltHit) begin
      haltAck_reg  <= 1'b1;
      haltWait_reg <= '0;
    end else if (haltAck_reg) begin
      if (haltWait_reg == 2'(WAIT_STATES)) begin
        haltAck_reg <= 1'b0;
      end else begin
        haltWait_reg <= haltWait_reg + 1'b1;
      end
    end
  end

  // ready is a one-cycle low acknowledge, blocked while the coprocessor is held off
  // limitation: an acknowledge that falls in the hold-off is dropped, not retried
  always_ff @(posedge core_clk) begin
    if (reset || brdSync) begin
      readyOutN <= 1'b1;
    end else begin
      readyOutN <= !(((cpuState_reg == CPU_ACK && cpuCnt_reg == CNT_W'(WAIT_STATES))
                      || (haltAck_reg && haltWait_reg == 2'(WAIT_STATES)))
                     && !coproPulse_reg && readyHold_reg == '0);
    end
  end

  always_ff @(posedge core_clk) begin
    // defaults load one clock behind reset so the output stays flop-driven
    configDefaultsLoad <= reset || brdSync;
  end
endmodule : cpu_copro_reset_generator
`default_nettype wire

/* src/reset_gen_pkg.sv */
/*
  constants and carrier types for the processor/coprocessor reset generator.
  assumes core_clk is the double-rate processor clock at 40 MHz.
*/
//
// Contract
// - board reset clears all state and resets both processor and coprocessor.
// - during board reset the busy line is held at least eight clocks before and after the processor reset falls.
// - a keyboard-controller reset request gives an immediate 16-clock processor-only reset.
// - setting bit 0 of port 92h gives a processor-only 16-clock reset after about 6.75 us.
// - a read of port EFh does the same, but only while the compatibility feature set is enabled.
// - a write to port F1h gives an 80-clock coprocessor-only reset.
// - ready is withheld a further 100 clocks after the coprocessor reset ends.
// - a shutdown cycle gives a 16-clock processor-only reset.
// - a shutdown is acknowledged with ready after two wait states, and the reset pulse starts in that same cycle.
// - a special cycle with data/control 0 and write/read 1 is shutdown when byte lane 0 enable is 0, halt when 1.
package reset_gen_pkg;
  localparam int  CLK_MHZ          = 40;
  localparam real PRE_DELAY_US     = 6.75;
  localparam int  PRE_DELAY_CYCLES = int'(PRE_DELAY_US * CLK_MHZ - 0.5); // longest time rounds down
  localparam int  CPU_PULSE_CYCLES = 16;
  localparam int  COPRO_PULSE_CYCLES = 80;
  localparam int  READY_HOLD_CYCLES  = 100;
  localparam int  BUSY_MARGIN_CYCLES = 8;
  localparam int  WAIT_STATES        = 2;
  localparam int  CNT_W              = 9;

  typedef struct packed {
    logic valid;     // one-cycle strobe: special cycle on the bus
    logic dataCtrl;  // data/control
    logic writeRead; // write/read
    logic byteLane0EnableN;
  } special_cycle_type;

  typedef struct packed {
    logic port92Bit0Set;      // pulse: bit 0 of port 92h written to 1
    logic portEfRead;         // pulse
    logic coproResetPortWrite;// pulse: port F1h written
  } io_trigger_type;

  typedef enum logic [4:0] {
    CPU_IDLE  = 5'b00001,
    CPU_DELAY = 5'b00010,
    CPU_ACK   = 5'b00100,
    CPU_PULSE = 5'b01000,
    CPU_BOARD = 5'b10000
  } cpu_state_type;
endpackage : reset_gen_pkg

/* test/reset_gen_properties.sv */
/* timing checks between the reset generator's triggers and its outputs.
   assumes the bench keeps the sequencer idle before each trigger; bound below. */
`timescale 1ns/10ps
`default_nettype none
module reset_gen_properties
  import reset_gen_pkg::*;
#(
  parameter int PRE_DELAY = PRE_DELAY_CYCLES
)(
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              boardResetIn,
  input wire logic              kbdCpuResetReqN,
  input wire logic              compatFeatureEnable,
  input wire io_trigger_type    ioTrig,
  input wire special_cycle_type specialCycle,
  input wire logic              cpuResetOut,
  input wire logic              coproResetOut,
  input wire logic              cpuBusyOutN,
  input wire logic              readyOutN,
  input wire logic              configDefaultsLoad
);
  localparam int PD_HI = PRE_DELAY + 1;
  logic [7:0] gap_reg;
  logic [7:0] run_reg;
  logic       special;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  assign special = specialCycle.valid && !specialCycle.dataCtrl && specialCycle.writeRead;
  // both saturate so a long quiet spell never wraps back into range
  always_ff @(posedge core_clk) begin
    gap_reg <= (reset || coproResetOut) ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hFF};
  end
  always_ff @(posedge core_clk) begin
    run_reg <= (reset || !coproResetOut) ? 8'h00 : run_reg + {7'h00, run_reg != 8'hFF};
  end
  chk_board_reset: assert property (
    $rose(boardResetIn) |-> ##[1:4] (cpuResetOut && coproResetOut && configDefaultsLoad))
    else $error("board reset not applied");
  chk_busy_before: assert property (
    $fell(cpuResetOut) && !cpuBusyOutN |-> !$past(cpuBusyOutN, 8))
    else $error("busy short before reset fall");
  chk_busy_after: assert property (
    $fell(cpuResetOut) && !cpuBusyOutN |-> !cpuBusyOutN[*8])
    else $error("busy short after reset fall");
  chk_kbd_reset: assert property (
    $fell(kbdCpuResetReqN) |-> ##[1:5] $rose(cpuResetOut))
    else $error("keyboard reset late");
  chk_port_delay: assert property (
    ioTrig.port92Bit0Set || ioTrig.portEfRead && compatFeatureEnable |-> ##[PRE_DELAY:PD_HI] $rose(cpuResetOut))
    else $error("port reset delay wrong");
  chk_read_gated: assert property (
    ioTrig.portEfRead && !compatFeatureEnable |-> ##1 !cpuResetOut[*8])
    else $error("gated read reset");
  chk_cpu_width: assert property (
    $rose(cpuResetOut) && !boardResetIn |-> ##15 cpuResetOut ##1 !cpuResetOut)
    else $error("processor reset width wrong");
  chk_copro_width: assert property (
    $fell(coproResetOut) |-> run_reg >= 8'h50)
    else $error("coprocessor reset short");
  chk_ready_hold: assert property (
    !readyOutN |-> !coproResetOut && gap_reg >= 8'h64)
    else $error("ready during holdoff");
  chk_shutdown_ack: assert property (
    special && !specialCycle.byteLane0EnableN |=> readyOutN[*3] ##1 (!readyOutN && $rose(cpuResetOut)))
    else $error("shutdown ack wrong");
  chk_halt_ack: assert property (
    special && specialCycle.byteLane0EnableN |=> readyOutN[*3] ##1 (!readyOutN && !cpuResetOut) ##1 readyOutN)
    else $error("halt ack wrong");
endmodule : reset_gen_properties
bind cpu_copro_reset_generator reset_gen_properties #(.PRE_DELAY(PRE_DELAY)) u_reset_gen_properties (.core_clk,
  .reset, .boardResetIn, .kbdCpuResetReqN, .compatFeatureEnable, .ioTrig, .specialCycle, .cpuResetOut,
  .coproResetOut, .cpuBusyOutN, .readyOutN, .configDefaultsLoad);
`default_nettype wire

/* test/reset_target_model.sv */
/* processor and coprocessor reset inputs: measure each pulse they receive.
   assumes one pulse ends at a time; coprocessor widths are reported plus 1000. */
`timescale 1ns/10ps
`default_nettype none
module reset_target_model (
  input  wire logic core_clk,
  input  wire logic cpuResetOut,
  input  wire logic coproResetOut,
  output var  logic doneStb = 1'b0,
  output var  int   result
);
  int cpuRun = 0;
  int coproRun = 0;
  always @(posedge core_clk) begin
    doneStb <= 1'b0;
    cpuRun <= cpuResetOut ? cpuRun + 1 : 0;
    coproRun <= coproResetOut ? coproRun + 1 : 0;
    if (!cpuResetOut && cpuRun > 0) begin
      doneStb <= 1'b1;
      result <= cpuRun;
    end
    if (!coproResetOut && coproRun > 0) begin
      doneStb <= 1'b1;
      result <= 1000 + coproRun;
    end
  end
endmodule : reset_target_model
`default_nettype wire

/* test/cpu_copro_reset_generator_test.sv */
/* bench: drives triggers, queues expected pulse widths, compares with the model.
   assumes the pre-reset delay shortened to 4 cycles to keep the run short. */
`timescale 1ns/10ps
`default_nettype none
module cpu_copro_reset_generator_test;
  import reset_gen_pkg::*;
  logic core_clk = 0, reset = 1, boardResetIn = 0, kbdCpuResetReqN = 1, compatFeatureEnable = 0, armed = 0;
  logic cpuResetOut, coproResetOut, cpuBusyOutN, readyOutN, configDefaultsLoad, doneStb;
  io_trigger_type    ioTrig = '0;
  special_cycle_type specialCycle = '0;
  io_trigger_type    trigs[4] = '{3'b100, 3'b010, 3'b010, 3'b001};
  special_cycle_type cycs[3] = '{4'b1011, 4'b1111, 4'b1010};
  int expects[4] = '{CPU_PULSE_CYCLES, CPU_PULSE_CYCLES, 0, 1000 + COPRO_PULSE_CYCLES};
  int result, fails = 0, n_tests = 0;
  int expQ[$];
  initial forever #12.5 core_clk = ~core_clk;
  cpu_copro_reset_generator #(.PRE_DELAY(4)) u_cpu_copro_reset_generator (.core_clk, .reset, .boardResetIn,
    .kbdCpuResetReqN, .compatFeatureEnable, .ioTrig, .specialCycle, .cpuResetOut, .coproResetOut,
    .cpuBusyOutN, .readyOutN, .configDefaultsLoad);
  reset_target_model u_reset_target_model (.core_clk, .cpuResetOut, .coproResetOut, .doneStb, .result);
  task automatic complete_run;
    fails += expQ.size();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic check_width(input int got);
    n_tests++;
    if (expQ.size() == 0 || got != expQ[0]) begin
      fails++;
      $display("mismatch at %0t: pulse code %0d", $time, got);
    end
    if (expQ.size() > 0) void'(expQ.pop_front());
  endtask : check_width
  task automatic fire(input io_trigger_type t);
    @(negedge core_clk) ioTrig = t;
    @(negedge core_clk) ioTrig = '0;
  endtask : fire
  // long enough for an 80-cycle pulse plus the 100-cycle ready holdoff
  task automatic settle;
    repeat (250 + $urandom_range(0, 20)) @(negedge core_clk);
  endtask : settle
  always @(posedge core_clk) if (armed && doneStb === 1'b1) check_width(result);
  initial begin
    #150000;
    fails++;
    complete_run;
  end
  initial begin
    void'($urandom(54905));
    repeat (20) @(negedge core_clk);
    reset = 0;
    settle;
    armed = 1;
    expQ.push_back(CPU_PULSE_CYCLES);
    kbdCpuResetReqN = 0;
    repeat ($urandom_range(2, 6)) @(negedge core_clk);
    kbdCpuResetReqN = 1;
    settle;
    for (int i = 0; i < 4; i++) begin
      compatFeatureEnable = (i != 2);
      if (expects[i] != 0) expQ.push_back(expects[i]);
      fire(trigs[i]);
      settle;
    end
    for (int i = 0; i < 3; i++) begin
      if (i == 2) expQ.push_back(CPU_PULSE_CYCLES);
      @(negedge core_clk) specialCycle = cycs[i];
      @(negedge core_clk) specialCycle = '0;
      settle;
    end
    expQ.push_back(1002 + COPRO_PULSE_CYCLES);
    fire(3'b001);
    fire(3'b001);
    settle;
    armed = 0;
    boardResetIn = 1;
    repeat (20) @(negedge core_clk);
    boardResetIn = 0;
    settle;
    complete_run;
  end
endmodule : cpu_copro_reset_generator_test
`default_nettype wire
